//--- dv/hap_master_model.sv
// external master that pushes and pulls words
`timescale 1ns/10ps
module hap_master_model (
  input  logic       clk,
  input  logic [7:0] port0_out,
  input  logic [7:0] port1_out,
  input  logic [7:0] port2_out,
  input  logic       port0_oe_n,
  input  logic       port1_oe_n,
  input  logic       port2_oe_n,
  output logic [7:0] port0_in,
  output logic [7:0] port1_in,
  output logic [7:0] port2_in,
  output logic       input_strobe_n = 1'b1,
  output logic       out_drive_en_n = 1'b1,
  output logic       chip_sel_n = 1'b1
);
  logic [23:0] dat = 24'h5a5a5a;
  assign port0_in = port0_oe_n ? dat[7:0] : port0_out;
  assign port1_in = port1_oe_n ? dat[15:8] : port1_out;
  assign port2_in = port2_oe_n ? dat[23:16] : port2_out;
  task automatic push(input logic [23:0] w, input int hold, input logic sel);
    @(posedge clk);
    dat <= w;
    input_strobe_n <= 1'b0;
    chip_sel_n <= ~sel;
    repeat (hold) @(posedge clk);
    input_strobe_n <= 1'b1;
    chip_sel_n <= 1'b1;
    // released lanes invert so stale data never looks valid
    dat <= ~w;
    repeat (5) @(posedge clk);
  endtask
  task automatic pull(output logic [23:0] w, input int hold);
    @(posedge clk);
    out_drive_en_n <= 1'b0;
    chip_sel_n <= 1'b0;
    repeat (hold) @(posedge clk);
    w = {port2_in, port1_in, port0_in};
    out_drive_en_n <= 1'b1;
    chip_sel_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
endmodule

//--- dv/hap_port_assertions.sv
// port assertions for the assisted parallel port
`timescale 1ns/10ps
module hap_port_assertions (
  input logic        clk,
  input logic        rst_n,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_wvalid,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic        port0_oe_n,
  input logic        port1_oe_n,
  input logic        port2_oe_n,
  input logic        input_strobe_n,
  input logic        out_drive_en_n,
  input logic        chip_sel_n,
  input logic        room_for_input_pin,
  input logic        output_valid_pin
);
  // recent register traffic, so pin moves can be traced to a cause
  logic [3:0] bus_hist;
  always @(posedge clk) bus_hist <= {bus_hist[2:0], s_axi_arvalid | s_axi_wvalid};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid lost");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("rdata lost");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  drive_gate_a: assert property (
    $fell(port0_oe_n) |-> $past(!chip_sel_n && !out_drive_en_n, 2)) else $error("bad drive");
  drive_end_a: assert property (
    $rose(out_drive_en_n) |-> ##[1:6] port0_oe_n) else $error("drive stuck");
  lane_order_a: assert property (
    !port2_oe_n |-> !port1_oe_n && !port0_oe_n) else $error("lane order");
  valid_cause_a: assert property (
    $changed(output_valid_pin) |-> |bus_hist || $past(!out_drive_en_n && !chip_sel_n, 2))
    else $error("valid moved alone");
  room_cause_a: assert property (
    $changed(room_for_input_pin) |-> |bus_hist || $past(!input_strobe_n && !chip_sel_n, 2))
    else $error("room moved alone");
  cover property ($fell(port0_oe_n));
  cover property (!port2_oe_n);
  cover property ($fell(input_strobe_n) && !chip_sel_n);
endmodule
bind hap_port hap_port_assertions u_chk (.*);

//--- dv/hw_assisted_parallel_port_test.sv
// self-checking bench for the assisted parallel port
`timescale 1ns/10ps
`include "hap_defs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module hw_assisted_parallel_port_test;
  typedef struct packed {logic [7:0] cfg; logic [23:0] w; logic [23:0] m;} hap_row_t;
  localparam logic [1:0] ok = `HAP_RESP_OKAY;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        port0_oe_n, port1_oe_n, port2_oe_n, room_for_input_pin, output_valid_pin;
  logic        irq, input_strobe_n, out_drive_en_n, chip_sel_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  port0_in, port1_in, port2_in, port0_out, port1_out, port2_out;
  logic [31:0] s_axi_rdata, d0, d1, d2;
  logic [23:0] got;
  int          err_count = 0, cmp_count = 0;
  hap_row_t    r;
  hap_row_t    rows [4] = '{'{8'h80, 24'h11c35a, 24'hff}, '{8'hb1, 24'h2ba5e7, 24'hffff},
                            '{8'h92, 24'h3d6e94, 24'hffffff}, '{8'ha3, 24'h4f0871, 24'hff}};
  always #12.5 clk = ~clk;
  hap_port u_dut (.*);
  hap_master_model u_mst (.*);
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one register access, write when w is set
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
    q = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n >= 40) begin
      err_count++;
      $display("Error %0t: bus timeout", $time);
      finish_test();
    end else begin
      `CHK(w ? s_axi_bresp : s_axi_rresp, e)
    end
  endtask
  initial begin
    tick(8);
    rst_n <= 1'b1;
    acc(1, `HAP_OFF_IRQ_MSK, 8'h03, d0, ok);
    foreach (rows[i]) begin
      r = rows[i];
      acc(1, `HAP_OFF_CFG, r.cfg, d0, ok);
      tick(3);
      `CHK({room_for_input_pin, output_valid_pin}, {~r.cfg[5], r.cfg[4]})
      acc(0, `HAP_OFF_CFG, 8'h0, d0, ok);
      `CHK(d0, {24'h0, r.cfg[7:4], r.cfg[5], ~r.cfg[4], r.cfg[1:0]})
      u_mst.push(r.w, 4 + i, 1'b1);
      `CHK({room_for_input_pin, irq}, {r.cfg[5], 1'b1})
      acc(0, `HAP_OFF_IRQ_ST, 8'h0, d0, ok);
      `CHK({d0, irq}, {32'h2, 1'b0})
      acc(0, `HAP_OFF_PORT2, 8'h0, d2, ok);
      acc(0, `HAP_OFF_PORT1, 8'h0, d1, ok);
      `CHK(room_for_input_pin, r.cfg[5])
      acc(0, `HAP_OFF_PORT0, 8'h0, d0, ok);
      tick(2);
      `CHK(room_for_input_pin, ~r.cfg[5])
      `CHK({d2[7:0], d1[7:0], d0[7:0]} & r.m, r.w & r.m)
      acc(1, `HAP_OFF_PORT2, r.w[23:16], d0, ok);
      acc(1, `HAP_OFF_PORT1, r.w[15:8], d0, ok);
      tick(2);
      `CHK(output_valid_pin, r.cfg[4])
      acc(1, `HAP_OFF_PORT0, r.w[7:0], d0, ok);
      tick(2);
      `CHK(output_valid_pin, ~r.cfg[4])
      u_mst.pull(got, 6 + i);
      `CHK({got & r.m, output_valid_pin}, {r.w & r.m, r.cfg[4]})
      acc(0, `HAP_OFF_IRQ_ST, 8'h0, d0, ok);
      `CHK(d0, 32'h1)
    end
    u_mst.push(24'h00e0e0, 5, 1'b0);
    acc(0, `HAP_OFF_IRQ_ST, 8'h0, d0, ok);
    `CHK({d0, room_for_input_pin}, {32'h0, ~r.cfg[5]})
    acc(1, `HAP_OFF_IRQ_MSK, 8'h00, d0, ok);
    u_mst.push(24'h0000c6, 5, 1'b1);
    `CHK(irq, 1'b0)
    acc(0, `HAP_OFF_IRQ_ST, 8'h0, d0, ok);
    acc(0, `HAP_OFF_PORT0, 8'h0, d1, ok);
    `CHK({d0, d1}, {32'h2, 32'hc6})
    acc(0, `HAP_OFF_PORT1, 8'h0, d2, ok);
    `CHK(d2, {24'h0, rows[2].w[15:8]})
    acc(1, 8'h18, 8'hff, d0, `HAP_RESP_SLVERR);
    acc(0, 8'h18, 8'h0, d0, `HAP_RESP_SLVERR);
    `CHK(d0, 32'h0)
    rst_n <= 1'b0;
    tick(8);
    rst_n <= 1'b1;
    acc(0, `HAP_OFF_CFG, 8'h0, d0, ok);
    acc(0, `HAP_OFF_IRQ_MSK, 8'h0, d1, ok);
    `CHK({d0, d1, output_valid_pin, port0_oe_n, irq}, {32'h4, 32'h0, 3'b010})
    finish_test();
  end
endmodule

//--- include/hap_defs.vh
// constants for the assisted parallel port: map, fields, reset values
`ifndef HAP_DEFS_VH
`define HAP_DEFS_VH

`define HAP_ADDR_W      8
`define HAP_OFF_CFG     8'h00
`define HAP_OFF_PORT0   8'h04
`define HAP_OFF_PORT1   8'h08
`define HAP_OFF_PORT2   8'h0c
`define HAP_OFF_IRQ_ST  8'h10
`define HAP_OFF_IRQ_MSK 8'h14

`define HAP_CFG_WID_LO  0
`define HAP_CFG_WID_HI  1
`define HAP_CFG_VALID   2
`define HAP_CFG_ROOM    3
`define HAP_CFG_VPOL    4
`define HAP_CFG_RPOL    5
`define HAP_CFG_EN      7

`define HAP_WID_8       2'b00
`define HAP_WID_16      2'b01
`define HAP_WID_24      2'b10

`define HAP_IRQ_OE      0
`define HAP_IRQ_STB     1

`define HAP_RST_CFG     8'h00
`define HAP_RST_MSK     2'b00
`define HAP_SYNC_STAGES 2

`define HAP_RESP_OKAY   2'b00
`define HAP_RESP_SLVERR 2'b10

`endif

//--- rtl/hap_port.v
// assisted parallel port with axi4-lite register access
`timescale 1ns/10ps
`include "hap_defs.vh"
module hap_port (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire [`HAP_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`HAP_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  input  wire [7:0]             port0_in,
  output reg  [7:0]             port0_out,
  output reg                    port0_oe_n,
  input  wire [7:0]             port1_in,
  output reg  [7:0]             port1_out,
  output reg                    port1_oe_n,
  input  wire [7:0]             port2_in,
  output reg  [7:0]             port2_out,
  output reg                    port2_oe_n,
  input  wire                   input_strobe_n,
  input  wire                   out_drive_en_n,
  input  wire                   chip_sel_n,
  output reg                    room_for_input_pin,
  output reg                    output_valid_pin,
  output wire                   irq
);

  // number of byte lanes in use for a width code
  function [1:0] lanes;
    input [1:0] wid;
    begin
      case (wid)
        `HAP_WID_16: lanes = 2'd2;
        `HAP_WID_24: lanes = 2'd3;
        default:     lanes = 2'd1;
      endcase
    end
  endfunction

  // address decode shared by read and write paths
  function mapped;
    input [`HAP_ADDR_W-1:0] a;
    begin
      case (a)
        `HAP_OFF_CFG, `HAP_OFF_PORT0, `HAP_OFF_PORT1, `HAP_OFF_PORT2,
        `HAP_OFF_IRQ_ST, `HAP_OFF_IRQ_MSK: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  reg  [7:0]             cfg_r;
  reg  [1:0]             msk_r;
  reg  [1:0]             ist_r;
  reg  [1:0]             ist_nxt;
  reg                    valid_r;
  reg                    valid_nxt;
  reg                    room_r;
  reg                    room_nxt;
  reg  [7:0]             out0_r;
  reg  [7:0]             out1_r;
  reg  [7:0]             out2_r;
  reg  [7:0]             in0_r;
  reg  [7:0]             in1_r;
  reg  [7:0]             in2_r;
  reg                    aw_held_r;
  reg  [`HAP_ADDR_W-1:0] aw_addr_r;
  reg                    w_held_r;
  reg  [7:0]             w_data_r;
  reg                    w_lane0_r;
  reg                    stb_act_d_r;
  reg                    oe_act_d_r;
  wire [2:0]             hs_sync;
  wire                   en;
  wire [1:0]             nl;
  wire                   stb_act;
  wire                   oe_act;
  wire                   stb_start;
  wire                   stb_end;
  wire                   oe_start;
  wire                   oe_end;
  wire                   do_wr;
  wire                   do_rd;
  wire                   wr_p0;
  wire                   rd_p0;
  wire                   rd_ist;

  hap_sync #(
    .W (3)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({chip_sel_n, out_drive_en_n, input_strobe_n}),
    .dout  (hs_sync)
  );

  assign en = cfg_r[`HAP_CFG_EN];
  assign nl = lanes(cfg_r[`HAP_CFG_WID_HI:`HAP_CFG_WID_LO]);

  assign stb_act = en & ~hs_sync[0] & ~hs_sync[2];
  assign oe_act  = en & ~hs_sync[1] & ~hs_sync[2];

  assign stb_start = stb_act & ~stb_act_d_r;
  assign stb_end   = ~stb_act & stb_act_d_r;
  assign oe_start  = oe_act & ~oe_act_d_r;
  assign oe_end    = ~oe_act & oe_act_d_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      stb_act_d_r <= 1'b0;
      oe_act_d_r  <= 1'b0;
    end else begin
      stb_act_d_r <= stb_act;
      oe_act_d_r  <= oe_act;
    end
  end

  // bus write side: address and data accepted in either order
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  assign do_wr = aw_held_r & w_held_r & ~s_axi_bvalid;
  // only port 0 write raises valid
  assign wr_p0  = do_wr & w_lane0_r & (aw_addr_r == `HAP_OFF_PORT0);

  always @(posedge clk) begin
    if (!rst_n) begin
      aw_held_r    <= 1'b0;
      aw_addr_r    <= {`HAP_ADDR_W{1'b0}};
      w_held_r     <= 1'b0;
      w_data_r     <= 8'h00;
      w_lane0_r    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HAP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r  <= 1'b1;
        w_data_r  <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? `HAP_RESP_OKAY : `HAP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable registers and outbound latches
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_r  <= `HAP_RST_CFG;
      msk_r  <= `HAP_RST_MSK;
      out0_r <= 8'h00;
      out1_r <= 8'h00;
      out2_r <= 8'h00;
    end else if (do_wr && w_lane0_r) begin
      case (aw_addr_r)
        // status bits 2 and 3 are read-only
        `HAP_OFF_CFG: begin
          cfg_r <= w_data_r & 8'hb3;
        end
        `HAP_OFF_PORT0: begin
          out0_r <= w_data_r;
        end
        `HAP_OFF_PORT1: begin
          out1_r <= w_data_r;
        end
        `HAP_OFF_PORT2: begin
          out2_r <= w_data_r;
        end
        `HAP_OFF_IRQ_MSK: begin
          msk_r <= w_data_r[1:0];
        end
        default: begin
          msk_r <= msk_r;
        end
      endcase
    end
  end

  // bus read side, one read at a time
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_rd  = s_axi_arvalid & s_axi_arready;
  // only port 0 read frees room
  assign rd_p0  = do_rd & (s_axi_araddr == `HAP_OFF_PORT0);
  assign rd_ist = do_rd & (s_axi_araddr == `HAP_OFF_IRQ_ST);

  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `HAP_RESP_OKAY;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `HAP_RESP_OKAY : `HAP_RESP_SLVERR;
      case (s_axi_araddr)
        // status bits read against the pin
        `HAP_OFF_CFG: begin
          s_axi_rdata <= {24'h00_0000, cfg_r[7:4],
                          cfg_r[`HAP_CFG_RPOL] ? room_r : ~room_r,
                          cfg_r[`HAP_CFG_VPOL] ? valid_r : ~valid_r,
                          cfg_r[1:0]};
        end
        `HAP_OFF_PORT0: begin
          s_axi_rdata <= {24'h00_0000, in0_r};
        end
        `HAP_OFF_PORT1: begin
          s_axi_rdata <= {24'h00_0000, in1_r};
        end
        `HAP_OFF_PORT2: begin
          s_axi_rdata <= {24'h00_0000, in2_r};
        end
        `HAP_OFF_IRQ_ST: begin
          s_axi_rdata <= {30'h0000_0000, ist_r};
        end
        `HAP_OFF_IRQ_MSK: begin
          s_axi_rdata <= {30'h0000_0000, msk_r};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // handshake flags; a set in the clearing cycle wins
  always @* begin
    valid_nxt = valid_r;
    room_nxt  = room_r;
    ist_nxt   = rd_ist ? 2'b00 : ist_r;
    if (oe_start) begin
      valid_nxt = 1'b0;
    end
    if (wr_p0) begin
      valid_nxt = 1'b1;
    end
    if (stb_start) begin
      room_nxt = 1'b0;
    end
    if (rd_p0) begin
      room_nxt = 1'b1;
    end
    if (oe_end) begin
      ist_nxt[`HAP_IRQ_OE] = 1'b1;
    end
    if (stb_end) begin
      ist_nxt[`HAP_IRQ_STB] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
      room_r  <= 1'b1;
      ist_r   <= 2'b00;
    end else begin
      valid_r <= valid_nxt;
      room_r  <= room_nxt;
      ist_r   <= ist_nxt;
    end
  end

  assign irq = |(ist_r & msk_r);

  // data sampled at strobe start, held stable by master
  // capture only the lanes in use
  always @(posedge clk) begin
    if (!rst_n) begin
      in0_r <= 8'h00;
      in1_r <= 8'h00;
      in2_r <= 8'h00;
    end else if (stb_start) begin
      in0_r <= port0_in;
      if (nl >= 2'd2) begin
        in1_r <= port1_in;
      end
      if (nl == 2'd3) begin
        in2_r <= port2_in;
      end
    end
  end

  // drive pins; outputs push-pull while enabled
  always @(posedge clk) begin
    if (!rst_n) begin
      port0_out          <= 8'h00;
      port1_out          <= 8'h00;
      port2_out          <= 8'h00;
      port0_oe_n         <= 1'b1;
      port1_oe_n         <= 1'b1;
      port2_oe_n         <= 1'b1;
      output_valid_pin   <= 1'b0;
      room_for_input_pin <= 1'b0;
    end else begin
      port0_out  <= out0_r;
      port1_out  <= out1_r;
      port2_out  <= out2_r;
      port0_oe_n <= ~oe_act;
      port1_oe_n <= ~(oe_act & (nl >= 2'd2));
      port2_oe_n <= ~(oe_act & (nl == 2'd3));
      output_valid_pin <= en & (cfg_r[`HAP_CFG_VPOL] ? ~valid_r : valid_r);
      room_for_input_pin <= en & (cfg_r[`HAP_CFG_RPOL] ? ~room_r : room_r);
    end
  end

endmodule

//--- rtl/hap_sync.v
// two-stage synchroniser for the handshake inputs
`timescale 1ns/10ps
`include "hap_defs.vh"
module hap_sync #(
  parameter W = 3
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  // resets to all ones: the handshake inputs idle high
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= {W{1'b1}};
      sync_r <= {W{1'b1}};
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule
